// ===== include/cbt_pkg.sv
// package: constants for the command bus training link
package cbt_pkg;
	localparam int CLK_PERIOD_PS      = 100000;
	localparam int CKE_LOW_HOLD_PS    = 5000;
	localparam int CKE_LOW_HOLD_NCK   = 3;
	localparam int STROBE_PRE_PS      = 10000;
	localparam int FIRST_SAMPLE_PS    = 250000;
	localparam int ASYNC_READ_PS      = 20000;
	localparam int REF_LONG_PS        = 250000;
	localparam int REF_SHORT_PS       = 80000;
	localparam int CLK_PRE_CKEH_PS    = 1750;
	localparam int CLK_PRE_CKEH_NCK   = 3;
	localparam int STROBE_REL_PS      = 10000;
	localparam int EXIT_CMD_PS        = 200000;
	localparam int EXIT_CMD_NCK       = 5;
	localparam int TERM_LAT_PS        = 20000;
	localparam int DQ_TRI_PS          = 1500;
	localparam int SEL_TO_STROBE_NCK  = 2;
	localparam int STROBE_PULSES      = 2;
	localparam int CA_WIDTH           = 6;
	localparam int REF_WIDTH          = 7;
	localparam int DQ_WIDTH           = 16;
	localparam int CA_DQ_BASE         = 8;
	localparam int SET_SELECT_BIT     = 7;

	function automatic int ceil_cyc(input int ps);
		ceil_cyc = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (ceil_cyc < 1)
			ceil_cyc = 1;
	endfunction

	function automatic int floor_cyc(input int ps);
		floor_cyc = ps / CLK_PERIOD_PS;
		if (floor_cyc < 1)
			floor_cyc = 1;
	endfunction

	function automatic int max2(input int a, input int b);
		max2 = (a > b) ? a : b;
	endfunction

	localparam int CKE_LOW_HOLD_CYC  = max2(ceil_cyc(CKE_LOW_HOLD_PS), CKE_LOW_HOLD_NCK);
	localparam int STROBE_PRE_CYC    = ceil_cyc(STROBE_PRE_PS);
	localparam int FIRST_SAMPLE_CYC  = ceil_cyc(FIRST_SAMPLE_PS);
	localparam int ASYNC_READ_CYC    = floor_cyc(ASYNC_READ_PS);
	localparam int SAMPLE_SPACE_CYC  = ceil_cyc(ASYNC_READ_PS);
	localparam int REF_LONG_CYC      = floor_cyc(REF_LONG_PS);
	localparam int REF_SHORT_CYC     = floor_cyc(REF_SHORT_PS);
	localparam int CLK_PRE_CKEH_CYC  = max2(ceil_cyc(CLK_PRE_CKEH_PS), CLK_PRE_CKEH_NCK);
	localparam int STROBE_REL_CYC    = ceil_cyc(STROBE_REL_PS);
	localparam int EXIT_CMD_CYC      = max2(ceil_cyc(EXIT_CMD_PS), EXIT_CMD_NCK);
	localparam int TERM_LAT_CYC      = ceil_cyc(TERM_LAT_PS);
	localparam int DQ_TRI_CYC        = ceil_cyc(DQ_TRI_PS);
	localparam int CNT_W             = 8;
endpackage

// ===== include/cbt_if.sv
// interface: link between controller and memory device
`timescale 1ns/1ps
interface cbt_if;
	logic                            cke;
	logic                            cs;
	logic [cbt_pkg::CA_WIDTH-1:0]    ca;
	logic                            strobe_t;
	logic                            strobe_c;
	logic                            strobe_oe;
	logic [cbt_pkg::DQ_WIDTH-1:0]    dq_ctl;
	logic                            dq_ctl_oe;
	logic [cbt_pkg::DQ_WIDTH-1:0]    dq_dev;
	logic                            dq_dev_oe;
	logic                            clk_run;

	modport ctl (
		output cke, cs, ca, strobe_t, strobe_c, strobe_oe, dq_ctl, dq_ctl_oe, clk_run,
		input  dq_dev, dq_dev_oe
	);
	modport dev (
		input  cke, cs, ca, strobe_t, strobe_c, strobe_oe, dq_ctl, dq_ctl_oe, clk_run,
		output dq_dev, dq_dev_oe
	);
endinterface

// ===== src/cbt_wait.sv
// module: down counter that reports when a wait has elapsed
`timescale 1ns/1ps
module cbt_wait #(
	parameter int W = cbt_pkg::CNT_W
) (
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);
	logic [W-1:0] remain;

	assign done = (remain == '0);

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			remain <= '0;
		else if (load)
			remain <= count;
		else if (!done)
			remain <= remain - W'(1);
	end
endmodule // cbt_wait

// ===== src/cbt_ctl.sv
// module: controller end of command bus training
`timescale 1ns/1ps
// Notes on behaviour
// - hold clock and deselect after cke low
// - two strobe pulses per reference value
// - device captures reference every strobe edge
// - short step only single step, one pulse; code still sends two pulses, only the wait is shorter
// - device swaps operating set at cke low
// - termination follows alternate set, pad gating
// - controller loads alternate set beforehand; cbt_ctl loads no set, tb_top drives ref_set0/ref_set1
// - clock valid before cke high
// - select low before cke high
// - device reverts set at cke high
// - trained values discarded, host rewrites
// - strobe low/high before cke low
// - wait before first sample command
// - device returns sample within async time
// - space sample commands by readback time
// - two cycles from select to strobe
// - clock valid around select pulse
// - release strobe after cke high
// - device tristates dq after cke high
// - termination latency from cke edge
// - wait before next command after exit
// - device maps ca0..5 onto dq8..13
// - exit write issued after cke high settle
// - bit 7 selects operating set; not decoded here, the device takes the set from set_control
module cbt_ctl (
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	cbt_if.ctl                                 link,
	input  wire logic                          start,
	input  wire logic                          ref_req,
	input  wire logic [cbt_pkg::REF_WIDTH-1:0] ref_value,
	input  wire logic                          ref_short,
	input  wire logic                          sample_req,
	input  wire logic [cbt_pkg::CA_WIDTH-1:0]  sample_ca,
	input  wire logic                          exit_req,
	output logic                               ready,
	output logic                               sample_valid,
	output logic [cbt_pkg::CA_WIDTH-1:0]       sample_data,
	output logic                               exit_write,
	output logic                               idle
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_STROBE_PRE, ST_CKE_HOLD, ST_ENTRY_WAIT, ST_READY,
		ST_SEL, ST_STROBE, ST_REF_WAIT, ST_SAMPLE, ST_EXIT_CLK, ST_EXIT_REL, ST_EXIT_CMD
	} cbt_state_e;

	localparam int W = cbt_pkg::CNT_W;

	// ************************************************************
	// state and counters
	// ************************************************************
	cbt_state_e                    state;
	cbt_state_e                    next_state;
	logic                          wait_load;
	logic [W-1:0]                  wait_count;
	logic                          wait_done;
	logic [1:0]                    pulses;
	logic [cbt_pkg::REF_WIDTH-1:0] ref_hold;

	cbt_wait #(.W(W)) cbt_wait_inst (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.load     (wait_load),
		.count    (wait_count),
		.done     (wait_done)
	);

	wire logic in_ready = (state == ST_READY);
	assign ready = in_ready;
	assign idle  = (state == ST_IDLE);

	// ************************************************************
	// next state and wait loads
	// ************************************************************
	always_comb begin
		next_state = state;
		wait_load  = 1'b0;
		wait_count = '0;
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_state = ST_STROBE_PRE;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::STROBE_PRE_CYC);
				end
			end
			ST_STROBE_PRE: begin
				if (wait_done) begin
					next_state = ST_CKE_HOLD;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::CKE_LOW_HOLD_CYC);
				end
			end
			ST_CKE_HOLD: begin
				if (wait_done) begin
					next_state = ST_ENTRY_WAIT;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::FIRST_SAMPLE_CYC - cbt_pkg::CKE_LOW_HOLD_CYC);
				end
			end
			ST_ENTRY_WAIT: begin
				if (wait_done)
					next_state = ST_READY;
			end
			ST_READY: begin
				if (exit_req) begin
					next_state = ST_EXIT_CLK;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::CLK_PRE_CKEH_CYC);
				end else if (ref_req) begin
					next_state = ST_SEL;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::SEL_TO_STROBE_NCK);
				end else if (sample_req) begin
					next_state = ST_SAMPLE;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::SAMPLE_SPACE_CYC);
				end
			end
			ST_SEL: begin
				if (wait_done)
					next_state = ST_STROBE;
			end
			ST_STROBE: begin
				if (pulses == 2'(cbt_pkg::STROBE_PULSES - 1)) begin
					next_state = ST_REF_WAIT;
					wait_load  = 1'b1;
					wait_count = ref_short ? W'(cbt_pkg::REF_SHORT_CYC)
						: W'(cbt_pkg::REF_LONG_CYC);
				end
			end
			ST_REF_WAIT: begin
				if (wait_done)
					next_state = ST_READY;
			end
			ST_SAMPLE: begin
				if (wait_done)
					next_state = ST_READY;
			end
			ST_EXIT_CLK: begin
				if (wait_done) begin
					next_state = ST_EXIT_REL;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::REF_LONG_CYC);
				end
			end
			ST_EXIT_REL: begin
				if (wait_done) begin
					next_state = ST_EXIT_CMD;
					wait_load  = 1'b1;
					wait_count = W'(cbt_pkg::EXIT_CMD_CYC);
				end
			end
			ST_EXIT_CMD: begin
				if (wait_done)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// ************************************************************
	// link drive
	// ************************************************************
	wire logic training  = (state != ST_IDLE) && (state != ST_STROBE_PRE)
		&& (state != ST_EXIT_REL) && (state != ST_EXIT_CMD);
	wire logic exiting   = (state == ST_EXIT_REL) || (state == ST_EXIT_CMD);
	wire logic strobe_on = (state != ST_IDLE) && !(exiting && wait_count == '0
		&& state == ST_EXIT_CMD);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state        <= ST_IDLE;
			pulses       <= '0;
			ref_hold     <= '0;
			sample_valid <= 1'b0;
			sample_data  <= '0;
			exit_write   <= 1'b0;
			link.cke        <= 1'b1;
			link.cs         <= 1'b0;
			link.ca         <= '0;
			link.strobe_t   <= 1'b0;
			link.strobe_c   <= 1'b1;
			link.strobe_oe  <= 1'b0;
			link.dq_ctl     <= '0;
			link.dq_ctl_oe  <= 1'b0;
			link.clk_run    <= 1'b1;
		end else begin
			state        <= next_state;
			sample_valid <= 1'b0;
			exit_write   <= (state == ST_EXIT_REL) && wait_done;
			link.cke     <= !training;
			link.clk_run <= 1'b1;
			link.strobe_oe <= strobe_on && (state != ST_EXIT_CMD);
			link.dq_ctl_oe <= (state == ST_SEL) || (state == ST_STROBE);
			if (state == ST_STROBE_PRE) begin
				link.strobe_t <= 1'b0;
				link.strobe_c <= 1'b1;
			end
			if (in_ready && ref_req && !exit_req) begin
				ref_hold    <= ref_value;
				link.cs     <= 1'b1;
				link.dq_ctl <= cbt_pkg::DQ_WIDTH'(ref_value);
				pulses      <= '0;
			end else if (in_ready && sample_req && !exit_req) begin
				link.cs <= 1'b1;
				link.ca <= sample_ca;
			end else begin
				link.cs <= 1'b0;
			end
			if (state == ST_STROBE) begin
				link.strobe_t <= !link.strobe_t;
				link.strobe_c <= !link.strobe_c;
				link.dq_ctl   <= cbt_pkg::DQ_WIDTH'(ref_hold);
				if (link.strobe_t)
					pulses <= pulses + 2'd1;
			end else if (state == ST_REF_WAIT) begin
				link.strobe_t <= 1'b0;
				link.strobe_c <= 1'b1;
			end
			if (state == ST_SAMPLE && wait_done) begin
				sample_valid <= 1'b1;
				sample_data  <= link.dq_dev[cbt_pkg::CA_DQ_BASE +: cbt_pkg::CA_WIDTH];
			end
		end
	end
endmodule // cbt_ctl

// ===== src/cbt_dev.sv
// module: device end of command bus training
`timescale 1ns/1ps
module cbt_dev (
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	cbt_if.dev                                 link,
	input  wire logic                          training_enable,
	input  wire logic                          set_control,
	input  wire logic [cbt_pkg::REF_WIDTH-1:0] ref_set0,
	input  wire logic [cbt_pkg::REF_WIDTH-1:0] ref_set1,
	input  wire logic                          term_en_set0,
	input  wire logic                          term_en_set1,
	input  wire logic                          term_pad_grounded,
	output logic                               operating_set_select,
	output logic [cbt_pkg::REF_WIDTH-1:0]      ca_reference_level,
	output logic                               ca_termination,
	output logic                               in_training
);
	logic                          cke_q;
	logic                          strobe_q;
	logic                          saved_set;
	logic [cbt_pkg::REF_WIDTH-1:0] captured;
	logic                          cap_new;
	logic                          term_target;
	logic [cbt_pkg::CNT_W-1:0]     term_cnt;
	logic [cbt_pkg::CNT_W-1:0]     tri_cnt;
	logic [cbt_pkg::CNT_W-1:0]     ref_cnt;

	wire logic cke_fall   = cke_q && !link.cke;
	wire logic cke_rise   = !cke_q && link.cke;
	wire logic strobe_edg = link.strobe_oe && (link.strobe_t != strobe_q);
	wire logic next_term  = !term_pad_grounded
		&& (operating_set_select ? term_en_set1 : term_en_set0);
	wire logic entry_term = !term_pad_grounded
		&& (operating_set_select ? term_en_set0 : term_en_set1);
	wire logic exit_term  = !term_pad_grounded
		&& (saved_set ? term_en_set1 : term_en_set0);

	// ************************************************************
	// set switching, capture and readback
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cke_q                <= 1'b1;
			strobe_q             <= 1'b0;
			saved_set            <= 1'b0;
			operating_set_select <= 1'b0;
			in_training          <= 1'b0;
			captured             <= '0;
			cap_new              <= 1'b0;
			ca_reference_level   <= '0;
			ref_cnt              <= '0;
			term_target          <= 1'b0;
			ca_termination       <= 1'b0;
			term_cnt             <= '0;
			tri_cnt              <= '0;
			link.dq_dev          <= '0;
			link.dq_dev_oe       <= 1'b0;
		end else begin
			cke_q    <= link.cke;
			strobe_q <= link.strobe_t;
			if (!in_training) begin
				operating_set_select <= set_control;
				ca_reference_level   <= set_control ? ref_set1 : ref_set0;
			end
			if (cke_fall && training_enable) begin
				saved_set            <= operating_set_select;
				operating_set_select <= !operating_set_select;
				ca_reference_level   <= operating_set_select ? ref_set0 : ref_set1;
				in_training          <= 1'b1;
				link.dq_dev_oe       <= 1'b1;
			end else if (cke_rise && in_training) begin
				operating_set_select <= saved_set;
				ca_reference_level   <= saved_set ? ref_set1 : ref_set0;
				in_training          <= 1'b0;
				cap_new              <= 1'b0;
				tri_cnt              <= cbt_pkg::CNT_W'(cbt_pkg::DQ_TRI_CYC);
			end else if (in_training && strobe_edg) begin
				captured <= link.dq_ctl[cbt_pkg::REF_WIDTH-1:0];
				cap_new  <= 1'b1;
				ref_cnt  <= cbt_pkg::CNT_W'(cbt_pkg::REF_SHORT_CYC);
			end else if (in_training && cap_new) begin
				if (ref_cnt == '0) begin
					ca_reference_level <= captured;
					cap_new            <= 1'b0;
				end else
					ref_cnt <= ref_cnt - 1'b1;
			end
			if (tri_cnt != '0) begin
				tri_cnt <= tri_cnt - 1'b1;
				if (tri_cnt == 1)
					link.dq_dev_oe <= 1'b0;
			end
			if (in_training && link.cs)
				link.dq_dev[cbt_pkg::CA_DQ_BASE +: cbt_pkg::CA_WIDTH] <= link.ca;
			if (cke_fall || cke_rise) begin
				term_target <= (cke_fall && training_enable) ? entry_term
					: (cke_rise && in_training) ? exit_term : next_term;
				term_cnt <= cbt_pkg::CNT_W'(cbt_pkg::TERM_LAT_CYC);
			end else if (term_cnt != '0) begin
				term_cnt <= term_cnt - 1'b1;
				if (term_cnt == 1)
					ca_termination <= term_target && !term_pad_grounded;
			end else if (!in_training) begin
				ca_termination <= next_term;
			end
		end
	end
endmodule // cbt_dev

// ===== testbench/cbt_link_chk.sv
// checker: timing relations on the training link
`timescale 1ns/1ps
module cbt_link_chk (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         cke,
	input  wire logic                         cs,
	input  wire logic [cbt_pkg::CA_WIDTH-1:0] ca,
	input  wire logic                         strobe_t,
	input  wire logic                         strobe_c,
	input  wire logic                         strobe_oe,
	input  wire logic [cbt_pkg::DQ_WIDTH-1:0] dq_dev,
	input  wire logic                         dq_dev_oe
);
	// ****************************************
	// cycles spent with cke low
	// ****************************************
	logic [7:0] low_cnt;
	always_ff @(posedge core_clk) begin
		if (sys_rst || cke)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_enter; cke ##1 !cke; endsequence
	sequence s_leave; !cke ##1 cke; endsequence
	sequence s_sample; !cke && cs; endsequence

	chk_hold_after_low: assert property (s_enter |-> !cs [*3])
		else $error("select raised too soon after cke low");
	chk_strobe_pre_low: assert property (s_enter |-> $past(strobe_oe) &&
		!$past(strobe_t) && $past(strobe_c))
		else $error("strobe not parked before cke low");
	chk_first_sample: assert property (s_sample |-> low_cnt >= 8'h03)
		else $error("sample command too soon after cke low");
	chk_select_strobe: assert property ($rose(cs) |-> $stable(strobe_t) [*2])
		else $error("strobe toggled too soon after select");
	chk_select_pre_high: assert property (s_leave |-> !cs && !$past(cs) &&
		!$past(cs, 2) && !$past(cs, 3))
		else $error("select not low before cke high");
	chk_strobe_release: assert property (s_leave |-> ##[0:4] !strobe_oe)
		else $error("strobe not released after exit");
	chk_dq_release: assert property (s_leave |-> ##[0:4] !dq_dev_oe)
		else $error("device dq not released after exit");
	chk_exit_gap: assert property (s_leave |-> !cs [*5])
		else $error("command too soon after exit");
	chk_readback_map: assert property (s_sample |=> dq_dev_oe &&
		dq_dev[cbt_pkg::CA_DQ_BASE +: cbt_pkg::CA_WIDTH] == $past(ca))
		else $error("sample not returned on dq");
endmodule // cbt_link_chk

// ===== testbench/tb_top.sv
// testbench: both ends joined, scoreboard on returned samples
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
	$display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end
module tb_top;
	logic                            core_clk, sys_rst;
	logic                            start, ref_req, ref_short, sample_req, exit_req;
	logic [cbt_pkg::REF_WIDTH-1:0]   ref_value, rv, ref_set0, ref_set1, ca_reference_level;
	logic [cbt_pkg::CA_WIDTH-1:0]    sample_ca, sample_data, exp_v;
	logic                            ready, sample_valid, exit_write, idle;
	logic                            training_enable, set_control, term_en_set0, term_en_set1;
	logic                            term_pad_grounded, operating_set_select;
	logic                            ca_termination, in_training;
	logic [cbt_pkg::CA_WIDTH-1:0]    exp_q[$];
	int                              miscompares, num_checks, cycles, seed;

	cbt_if link_if ();
	cbt_ctl cbt_ctl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(link_if),
		.start(start), .ref_req(ref_req), .ref_value(ref_value), .ref_short(ref_short),
		.sample_req(sample_req), .sample_ca(sample_ca), .exit_req(exit_req), .ready(ready),
		.sample_valid(sample_valid), .sample_data(sample_data), .exit_write(exit_write),
		.idle(idle));
	cbt_dev cbt_dev_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(link_if),
		.training_enable(training_enable), .set_control(set_control), .ref_set0(ref_set0),
		.ref_set1(ref_set1), .term_en_set0(term_en_set0), .term_en_set1(term_en_set1),
		.term_pad_grounded(term_pad_grounded), .operating_set_select(operating_set_select),
		.ca_reference_level(ca_reference_level), .ca_termination(ca_termination),
		.in_training(in_training));
	cbt_link_chk cbt_link_chk_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.cke(link_if.cke), .cs(link_if.cs), .ca(link_if.ca), .strobe_t(link_if.strobe_t),
		.strobe_c(link_if.strobe_c), .strobe_oe(link_if.strobe_oe), .dq_dev(link_if.dq_dev),
		.dq_dev_oe(link_if.dq_dev_oe));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic req(input logic [3:0] k);
		{exit_req, sample_req, ref_req, start} = k;
		tick(1);
		{exit_req, sample_req, ref_req, start} = 4'h0;
	endtask

	task automatic wait_for(input int w);
		int n;
		n = 0;
		while ((w == 0 ? ready : (w == 1 ? idle : exit_write)) !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		`CHK("handshake", 1, n < 200)
	endtask

	// ****************************************
	// scoreboard and timeout
	// ****************************************
	always @(negedge core_clk) begin
		cycles++;
		if (sample_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK("unexpected_sample", 1'b0, 1'b1)
			end else begin
				exp_v = exp_q.pop_front();
				`CHK("sample_data", exp_v, sample_data)
			end
		end
		if (cycles > 5000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ****************************************
	// stimulus
	// ****************************************
	initial begin
		seed = 32'h186f;
		{miscompares, num_checks, cycles} = '0;
		{exit_req, sample_req, ref_req, start, ref_short} = 5'h00;
		{ref_value, sample_ca} = '0;
		{training_enable, set_control, term_en_set0, term_en_set1, term_pad_grounded} = 5'h00;
		{ref_set0, ref_set1} = '0;
		sys_rst = 1'b1;
		tick(12);
		sys_rst = 1'b0;
		tick(1);
		req(4'h4);
		tick(4);
		for (int p = 0; p < 3; p++) begin
			set_control = p[0];
			term_pad_grounded = p[1];
			term_en_set0 = ~p[0];
			term_en_set1 = 1'b1;
			ref_set0 = 7'($random(seed)); // alternate set loaded before entry
			ref_set1 = 7'($random(seed));
			training_enable = 1'b1;
			tick(2);
			req(4'h1);
			wait_for(0);
			tick(2);
			`CHK("set_in_training", ~set_control, operating_set_select)
			`CHK("term_in_training", (set_control ? term_en_set0 : term_en_set1) & ~term_pad_grounded, ca_termination)
			`CHK("in_training", 1'b1, in_training)
			rv = 7'($random(seed));
			ref_value = rv;
			ref_short = 1'b0;
			req(4'h2);
			wait_for(0);
			tick(4);
			`CHK("ref_long", rv, ca_reference_level)
			ref_value = rv + 7'h01;
			ref_short = 1'b1;
			req(4'h2);
			wait_for(0);
			tick(4);
			`CHK("ref_short", ref_value, ca_reference_level)
			for (int k = 0; k < 4; k++) begin
				sample_ca = 6'($random(seed));
				exp_q.push_back(sample_ca);
				req(4'h4);
				wait_for(0);
			end
			req(4'h8);
			wait_for(2);
			training_enable = 1'b0; // exit write after settle
			wait_for(1);
			tick(3);
			`CHK("set_restored", set_control, operating_set_select)
			`CHK("ref_restored", set_control ? ref_set1 : ref_set0, ca_reference_level)
			`CHK("term_restored", (set_control ? term_en_set1 : term_en_set0) & ~term_pad_grounded, ca_termination)
			`CHK("out_of_training", 1'b0, in_training)
		end
		tick(10);
		`CHK("queue_drained", 0, exp_q.size())
		print_verdict();
	end
endmodule // tb_top
